// *** logic/tuner_regs_pkg.sv ***
// Purpose: constants and carriers for the tuner control register bank
// Assumes: one 250 MHz clock; bus pins sampled synchronously
// Notes: register offsets are byte addresses on the two-wire bus
// Contract
// - Prescale codes 0-6 divide by 8-14; code 7 divides by 2.
// - Pump current from level bit unless source select hands it to autotuner.
// - Reference divider is 1 when bit clear, 2 when set.
// - Pump test field: normal, low-z, source, sink, high-z codes.
// - Lock pin shows lock, N-divider halved or R-divider by selector.
// - Each block shutdown bit enables block at 0, disables at 1.
// - Bandgap goes off only once every other block is off.
// - Crystal oscillator runs unless both synth and refbuf are off.
// - Band field picks one of three bands; 00 turns oscillator off.
// - Sub-band field picks one of eight sub-bands.
// - Band from manual bits unless auto-select hands it to autotuner.
// - Latch bit latches tank ADC; read-enable exposes it; both reset 0.
// - Offset threshold field picks output window width.
// - Offset speed: 11 fast, 01 slow, 00 hold DAC values.
// - Offset mode: 00 off, 01/10 direct DAC, 11 automatic.
// - Offset DAC is nine bits, MSB in control register.
// - Power event flag reads 1 after reset, clears after reading 0x0C.
// - Overload bit reflects baseband above detection threshold.
// - Serial clock up to 400 kHz, generated by master.
// - Each byte takes nine clocks: eight data plus acknowledge.
// - Seven-bit slave address set by strap: C0/C1 or C4/C5.
// - Written bytes go to successive registers until STOP.
// - Read: address write, repeated START, data MSB first until NACK.
package tuner_regs_pkg;
   localparam logic [7:0] OFS_PLL = 8'h06;
   localparam logic [7:0] OFS_TEST = 8'h07;
   localparam logic [7:0] OFS_SHDN = 8'h08;
   localparam logic [7:0] OFS_OSC = 8'h09;
   localparam logic [7:0] OFS_BB = 8'h0A;
   localparam logic [7:0] OFS_DCCTL = 8'h0B;
   localparam logic [7:0] OFS_DACLO = 8'h0C;
   localparam logic [7:0] OFS_FADDR = 8'h0D;
   localparam logic [7:0] OFS_FDATA = 8'h0E;
   localparam logic [7:0] OFS_FREAD = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h11;
   localparam logic [7:0] OFS_ATUNE = 8'h12;
   localparam logic [7:0] RST_PLL = 8'h0A;
   localparam logic [7:0] RST_TEST = 8'h08;
   localparam logic [7:0] RST_SHDN = 8'h00;
   localparam logic [7:0] RST_OSC = 8'hC0;
   localparam logic [7:0] RST_BB = 8'h87;
   localparam logic [7:0] RST_DCCTL = 8'h40;
   localparam logic [7:0] RST_DACLO = 8'h00;
   localparam logic [7:0] RST_FADDR = 8'h00;
   localparam logic [7:0] RST_FDATA = 8'h00;
   // Bits with no function read back as zero
   localparam logic [7:0] RD_MASK_TEST = 8'hEF;
   localparam logic [7:0] RD_MASK_SHDN = 8'h7F;
   localparam logic [7:0] RD_MASK_BB = 8'hF7;
   localparam logic [5:0] SLAVE_ADDR_HI = 6'h30;
   localparam logic [3:0] PRESCALE_BASE = 4'h8;
   localparam logic [3:0] PRESCALE_XTAL4 = 4'h2;
   localparam int CLK_MHZ = 250;
   localparam int SCL_MAX_KHZ = 400;
   localparam int SCL_MIN_PERIOD_CYC = (CLK_MHZ * 1000) / SCL_MAX_KHZ;

   typedef enum logic [2:0] {
      PUMP_NORMAL = 3'h0,
      PUMP_LOW_Z = 3'h4,
      PUMP_SOURCE = 3'h5,
      PUMP_SINK = 3'h6,
      PUMP_HIGH_Z = 3'h7
   } pump_test_t;

   typedef struct packed {
      logic [3:0] slow_clock_div;
      logic ref_div_two;
      logic pump_auto;
      logic pump_high;
      logic [2:0] pump_test_mode;
      logic [2:0] lock_pin_select;
   } pll_ctl_t;

   typedef struct packed {
      logic bandgap_off;
      logic lna_off;
      logic mixer_off;
      logic baseband_off;
      logic synth_off;
      logic refbuf_off;
      logic xtal_off;
      logic osc_off;
   } power_ctl_t;

   typedef struct packed {
      logic [1:0] osc_band_sel;
      logic [2:0] osc_subband_sel;
      logic band_auto_sel;
      logic [1:0] offset_threshold;
      logic [1:0] offset_speed;
      logic [1:0] offset_mode;
      logic [8:0] offset_dac_value;
      logic offset_hold;
      logic offset_direct;
   } analog_ctl_t;

   typedef struct packed {
      logic lock_flag;
      logic autotune_status_a;
      logic autotune_status_e;
      logic offset_high_excursion;
      logic offset_low_excursion;
      logic gain_track;
      logic detector_over_flag;
      logic [4:0] autotune_band;
      logic [2:0] tank_adc;
   } analog_stat_t;
endpackage : tuner_regs_pkg

// *** logic/tuner_control_register_bank.sv ***
// Purpose: two-wire slave and control/status registers of the tuner
// Assumes: scl/sda sampled synchronously at 250 MHz, master drives scl
// Notes: sda_oe_n_o low means the pin is pulled low by this block
`timescale 1ns/10ps
module tuner_control_register_bank (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic addr_strap_pin_i,
   input wire logic [7:0] fuse_readback_i,
   input wire tuner_regs_pkg::analog_stat_t stat_i,
   output tuner_regs_pkg::pll_ctl_t pll_o,
   output tuner_regs_pkg::power_ctl_t power_o,
   output tuner_regs_pkg::analog_ctl_t analog_o,
   output logic [7:0] fuse_addr_o,
   output logic [7:0] fuse_data_o,
   output logic [1:0] filter_bw_extra_o,
   output logic [2:0] detector_threshold_o,
   output logic tune_adc_latch_o,
   output logic tune_adc_read_en_o
);
   import tuner_regs_pkg::*;

   typedef enum {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
   } bus_state_t;

   bus_state_t state;

   // Writable register images
   logic [7:0] r_pll;
   logic [7:0] r_test;
   logic [7:0] r_shdn;
   logic [7:0] r_osc;
   logic [7:0] r_bb;
   logic [7:0] r_dcctl;
   logic [7:0] r_daclo;
   logic [7:0] r_faddr;
   logic [7:0] r_fdata;

   // Serial engine state
   logic scl_q;
   logic sda_q;
   logic addr_strap;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] reg_ptr;
   logic [7:0] tx;
   logic [7:0] next_tx;
   logic first_byte;
   logic nack;
   logic addr_hit;

   // Status side
   logic power_event;
   logic adc_held_valid;
   logic [2:0] adc_held;

   // Bus events, one clock wide
   logic start_c;
   logic stop_c;
   logic scl_rise;
   logic scl_fall;
   logic wr_strobe;
   logic rd_done;

   function automatic logic [7:0] read_mux(input logic [7:0] a);
      unique case (a)
         OFS_PLL: read_mux = r_pll;
         OFS_TEST: read_mux = r_test & RD_MASK_TEST;
         OFS_SHDN: read_mux = r_shdn & RD_MASK_SHDN;
         OFS_OSC: read_mux = r_osc;
         OFS_BB: read_mux = r_bb & RD_MASK_BB;
         OFS_DCCTL: read_mux = r_dcctl;
         OFS_DACLO: read_mux = r_daclo;
         OFS_FADDR: read_mux = {4'h0, r_faddr[3:0]};
         OFS_FDATA: read_mux = r_fdata;
         OFS_FREAD: read_mux = fuse_readback_i;
         OFS_STAT: read_mux = {power_event,
            stat_i.autotune_status_a,
            stat_i.autotune_status_e,
            stat_i.lock_flag,
            stat_i.offset_low_excursion,
            stat_i.offset_high_excursion,
            stat_i.gain_track,
            stat_i.detector_over_flag};
         OFS_ATUNE: read_mux = {stat_i.autotune_band,
            r_osc[0] ? adc_held : 3'h0};
         default: read_mux = 8'h00;
      endcase
   endfunction : read_mux

   // Byte for the next read slot; its MSB must go out at the ACK fall
   always_comb begin
      next_tx = read_mux(reg_ptr);
   end

   // Strap sits in the second-lowest address bit
   assign addr_hit = (shift[7:1] == {SLAVE_ADDR_HI[5:1], addr_strap, 1'b0});

   // Edge detection on already-sampled pins; inputs count as synchronous
   assign start_c = scl_q && scl_i && sda_q && !sda_i;
   assign stop_c = scl_q && scl_i && !sda_q && sda_i;
   assign scl_rise = !scl_q && scl_i;
   assign scl_fall = scl_q && !scl_i;
   assign wr_strobe = (state == ST_WR) && scl_rise && (bit_cnt == 4'h7);
   assign rd_done = (state == ST_RD_ACK) && scl_rise;

   always_ff @(posedge clk_i) begin
      scl_q <= nrst_i ? scl_i : 1'b1;
      sda_q <= nrst_i ? sda_i : 1'b1;
   end

   // Strap follows the pin on every clock while the bus is idle
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         addr_strap <= 1'b0;
      end else if (state == ST_IDLE) begin
         addr_strap <= addr_strap_pin_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         reg_ptr <= 8'h00;
         first_byte <= 1'b0;
         nack <= 1'b0;
         tx <= 8'h00;
      end else if (start_c) begin
         state <= ST_ADDR;
         bit_cnt <= 4'h0;
      end else if (stop_c) begin
         state <= ST_IDLE;
      end else if (scl_rise) begin
         unique case (state)
            ST_ADDR, ST_WR: begin
               shift <= {shift[6:0], sda_i};
               bit_cnt <= bit_cnt + 4'h1;
            end
            ST_RD: begin
               bit_cnt <= bit_cnt + 4'h1;
            end
            ST_RD_ACK: begin
               nack <= sda_i;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (state)
            ST_ADDR: begin
               if (bit_cnt == 4'h8) begin
                  if (addr_hit) begin
                     state <= ST_ADDR_ACK;
                     first_byte <= !shift[0];
                     tx <= read_mux(reg_ptr);
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               bit_cnt <= 4'h0;
               state <= first_byte ? ST_WR : ST_RD;
            end
            ST_WR: begin
               if (bit_cnt == 4'h8) begin
                  state <= ST_WR_ACK;
                  if (first_byte) begin
                     reg_ptr <= shift;
                  end else begin
                     reg_ptr <= reg_ptr + 8'h01;
                  end
               end
            end
            ST_WR_ACK: begin
               bit_cnt <= 4'h0;
               first_byte <= 1'b0;
               state <= ST_WR;
            end
            ST_RD: begin
               if (bit_cnt == 4'h8) begin
                  state <= ST_RD_ACK;
                  reg_ptr <= reg_ptr + 8'h01;
               end else begin
                  tx <= {tx[6:0], 1'b0};
               end
            end
            ST_RD_ACK: begin
               bit_cnt <= 4'h0;
               tx <= next_tx;
               state <= nack ? ST_IDLE : ST_RD;
            end
            default: begin
            end
         endcase
      end
   end

   // SDA drive changes after SCL falls or is released at START/STOP, keeping data stable while high
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sda_oe_n_o <= 1'b1;
      end else if (start_c || stop_c) begin
         sda_oe_n_o <= 1'b1;
      end else if (scl_fall) begin
         unique case (state)
            ST_ADDR: sda_oe_n_o <= !(bit_cnt == 4'h8 && addr_hit);
            ST_WR: sda_oe_n_o <= !(bit_cnt == 4'h8);
            ST_ADDR_ACK: sda_oe_n_o <= first_byte ? 1'b1 : tx[7];
            ST_RD: sda_oe_n_o <= (bit_cnt == 4'h8) ? 1'b1 : tx[6];
            // Old tx is fully shifted here, so take the fresh byte
            ST_RD_ACK: sda_oe_n_o <= nack ? 1'b1 : next_tx[7];
            default: sda_oe_n_o <= 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      sda_o <= 1'b0;
   end

   // Data byte lands on its rising eighth bit; read-only slots ignored
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         r_pll <= RST_PLL;
         r_test <= RST_TEST;
         r_shdn <= RST_SHDN;
         r_osc <= RST_OSC;
         r_bb <= RST_BB;
         r_dcctl <= RST_DCCTL;
         r_daclo <= RST_DACLO;
         r_faddr <= RST_FADDR;
         r_fdata <= RST_FDATA;
      end else if (wr_strobe && !first_byte) begin
         unique case (reg_ptr)
            OFS_PLL: r_pll <= {shift[6:0], sda_i};
            OFS_TEST: r_test <= {shift[6:0], sda_i};
            OFS_SHDN: r_shdn <= {shift[6:0], sda_i};
            OFS_OSC: r_osc <= {shift[6:0], sda_i};
            OFS_BB: r_bb <= {shift[6:0], sda_i};
            OFS_DCCTL: r_dcctl <= {shift[6:0], sda_i};
            OFS_DACLO: r_daclo <= {shift[6:0], sda_i};
            OFS_FADDR: r_faddr <= {shift[6:0], sda_i};
            OFS_FDATA: r_fdata <= {shift[6:0], sda_i};
            default: begin
            end
         endcase
      end
   end

   // Set by reset, cleared after a readback of the DAC-low slot
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         power_event <= 1'b1;
      end else if (rd_done && reg_ptr == OFS_DACLO + 8'h01) begin
         power_event <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         adc_held <= 3'h0;
         adc_held_valid <= 1'b0;
      end else if (r_osc[1]) begin
         adc_held <= stat_i.tank_adc;
         adc_held_valid <= 1'b1;
      end
   end

   // Decoded controls
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pll_o <= '0;
      end else begin
         pll_o.slow_clock_div <= (r_pll[2:0] == 3'h7) ? PRESCALE_XTAL4 :
            PRESCALE_BASE + {1'b0, r_pll[2:0]};
         pll_o.ref_div_two <= r_pll[7];
         pll_o.pump_high <= r_pll[6];
         pll_o.pump_auto <= r_pll[5];
         pll_o.pump_test_mode <= r_test[7:5];
         pll_o.lock_pin_select <= r_test[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         power_o <= '0;
      end else begin
         power_o.lna_off <= r_shdn[0];
         power_o.baseband_off <= r_shdn[1];
         power_o.mixer_off <= r_shdn[2];
         power_o.synth_off <= r_shdn[3];
         power_o.refbuf_off <= r_shdn[4];
         power_o.xtal_off <= r_shdn[3] && r_shdn[4];
         power_o.osc_off <= (r_osc[7:6] == 2'h0);
         power_o.bandgap_off <= r_shdn[6] && (&r_shdn[5:0]) &&
            (r_osc[7:6] == 2'h0) && (r_dcctl[5:4] == 2'h0);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         analog_o <= '0;
         tune_adc_latch_o <= 1'b0;
         tune_adc_read_en_o <= 1'b0;
         detector_threshold_o <= 3'h0;
         filter_bw_extra_o <= 2'h0;
         fuse_addr_o <= 8'h00;
         fuse_data_o <= 8'h00;
      end else begin
         analog_o.osc_band_sel <= r_osc[7:6];
         analog_o.osc_subband_sel <= r_osc[5:3];
         analog_o.band_auto_sel <= r_osc[2];
         analog_o.offset_threshold <= r_dcctl[1:0];
         analog_o.offset_speed <= r_dcctl[3:2];
         analog_o.offset_mode <= r_dcctl[5:4];
         analog_o.offset_dac_value <= {r_dcctl[6], r_daclo};
         analog_o.offset_hold <= (r_dcctl[3:2] == 2'h0);
         analog_o.offset_direct <= r_dcctl[5] ^ r_dcctl[4];
         tune_adc_latch_o <= r_osc[1];
         tune_adc_read_en_o <= r_osc[0] && adc_held_valid;
         detector_threshold_o <= r_bb[2:0];
         filter_bw_extra_o <= {r_dcctl[7], r_bb[7]};
         fuse_addr_o <= {4'h0, r_faddr[3:0]};
         fuse_data_o <= r_fdata;
      end
   end
endmodule : tuner_control_register_bank

// *** bench/tuner_control_register_bank_monitor.sv ***
// Purpose: bus-side and decode checks for the tuner register bank
// Assumes: one clock domain, synchronous active-low reset
// Notes: decoded outputs settle one edge after reset release
`timescale 1ns/10ps
module tuner_control_register_bank_monitor (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_oe_n_o,
   input wire tuner_regs_pkg::pll_ctl_t pll_o,
   input wire tuner_regs_pkg::power_ctl_t power_o,
   input wire tuner_regs_pkg::analog_ctl_t analog_o
);
   import tuner_regs_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   property p_prescale;
      $past(nrst_i) |-> pll_o.slow_clock_div inside {[4'h8:4'hE], 4'h2};
   endproperty
   a_prescale: assert property (p_prescale) else $error("bad prescale ratio");
   property p_bandgap;
      power_o.bandgap_off |-> power_o.lna_off && power_o.mixer_off && power_o.baseband_off
         && power_o.synth_off && power_o.refbuf_off && power_o.osc_off
         && analog_o.offset_mode == 2'h0;
   endproperty
   a_bandgap: assert property (p_bandgap) else $error("bandgap off too early");
   property p_xtal;
      $past(nrst_i) |-> power_o.xtal_off == (power_o.synth_off && power_o.refbuf_off);
   endproperty
   a_xtal: assert property (p_xtal) else $error("crystal state wrong");
   property p_osc;
      $past(nrst_i) |-> power_o.osc_off == (analog_o.osc_band_sel == 2'h0);
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator off state wrong");
   property p_hold;
      $past(nrst_i) |-> analog_o.offset_hold == (analog_o.offset_speed == 2'h0);
   endproperty
   a_hold: assert property (p_hold) else $error("offset hold wrong");
   property p_direct;
      $past(nrst_i) |-> analog_o.offset_direct == (analog_o.offset_mode inside {2'h1, 2'h2});
   endproperty
   a_direct: assert property (p_direct) else $error("offset direct wrong");
   // Pin may only be taken while the clock is low
   property p_ack_low;
      $fell(sda_oe_n_o) |-> !scl_i;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("drive began with clock high");
   property p_steady;
      scl_i && $past(scl_i) |-> $stable(sda_oe_n_o);
   endproperty
   a_steady: assert property (p_steady) else $error("data moved with clock high");
   property p_ack_hold;
      $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("drive too short");
   c_ack: cover property ($fell(sda_oe_n_o));
   c_bandgap: cover property (power_o.bandgap_off);
   c_prescale2: cover property (pll_o.slow_clock_div == 4'h2);
endmodule : tuner_control_register_bank_monitor

// *** bench/two_wire_master_model.sv ***
// Purpose: two-wire bus master that drives the register bank
// Assumes: open-drain data line with pull-up, resolved by the bench; clock driven directly
// Notes: Q is a quarter bit time in clock cycles
`timescale 1ns/10ps
module two_wire_master_model #(parameter int Q = 160) (
   input wire logic clk_i,
   input wire logic sda_line_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask : tick
   // Data moves only while the clock is low
   task automatic bit_io(input logic b, output logic s);
      sda_o = b;
      tick(Q);
      scl_o = 1'b1;
      tick(Q);
      s = sda_line_i;
      tick(Q);
      scl_o = 1'b0;
      tick(Q);
   endtask : bit_io
   task automatic start;
      sda_o = 1'b1;
      tick(Q);
      scl_o = 1'b1;
      tick(Q);
      sda_o = 1'b0;
      tick(Q);
      scl_o = 1'b0;
      tick(Q);
   endtask : start
   task automatic stop;
      sda_o = 1'b0;
      tick(Q);
      scl_o = 1'b1;
      tick(Q);
      sda_o = 1'b1;
      tick(Q);
   endtask : stop
   // Send FF to read; ack_i high leaves the answer to the slave
   task automatic xfer(input logic [7:0] d, input logic ack_i, output logic [7:0] q,
                       output logic ack_o);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ack_i, ack_o);
   endtask : xfer
endmodule : two_wire_master_model

// *** bench/test_tuner_control_register_bank.sv ***
// Purpose: self-checking bench for the tuner register bank
// Assumes: strap low, so the bank answers at C0/C1
// Notes: bit time shortened; the bank samples the bus synchronously
`timescale 1ns/10ps
module test_tuner_control_register_bank;
   import tuner_regs_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic scl, msda, sda_o, sda_oe_n_o;
   wire logic sda_line = msda & (sda_oe_n_o | sda_o);
   pll_ctl_t pll_o;
   power_ctl_t power_o;
   analog_ctl_t analog_o;
   logic [7:0] fuse_addr_o, fuse_data_o;
   logic tune_adc_latch_o;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [7:0] got [13];
   // Columns: written, seen after reset, seen after write; offsets 06..12
   logic [7:0] rows [13][3] = '{'{8'h37, 8'h0A, 8'h37}, '{8'hFF, 8'h08, 8'hEF},
      '{8'hFF, 8'h00, 8'h7F}, '{8'h07, 8'hC0, 8'h07}, '{8'hFF, 8'h87, 8'hF7},
      '{8'hC3, 8'h40, 8'hC3}, '{8'hA5, 8'h00, 8'hA5}, '{8'hF3, 8'h00, 8'h03},
      '{8'h96, 8'h00, 8'h96}, '{8'h11, 8'h00, 8'h00}, '{8'h22, 8'h5A, 8'h5A},
      '{8'h33, 8'h39, 8'h39}, '{8'h44, 8'hA8, 8'hAD}};
   always #2 clk_i = ~clk_i;
   two_wire_master_model #(.Q(24)) m (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl),
      .sda_o(msda));
   tuner_control_register_bank uut (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .addr_strap_pin_i(1'b0),
      .fuse_readback_i(8'h5A), .stat_i(15'h55AD), .pll_o(pll_o), .power_o(power_o),
      .analog_o(analog_o), .fuse_addr_o(fuse_addr_o), .fuse_data_o(fuse_data_o),
      .filter_bw_extra_o(), .detector_threshold_o(), .tune_adc_latch_o(tune_adc_latch_o),
      .tune_adc_read_en_o());
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task automatic dev_byte(input logic [7:0] d);
      logic [7:0] q;
      logic a;
      m.xfer(d, 1'b1, q, a);
      check(a, 1'b0);
   endtask : dev_byte
   task automatic read_from(input logic [7:0] r, input int n);
      logic [7:0] q;
      logic a;
      m.start();
      dev_byte(8'hC0);
      dev_byte(r);
      m.start();
      dev_byte(8'hC1);
      for (int i = 0; i < n; i++) begin
         m.xfer(8'hFF, i == n - 1, q, a);
         got[i] = q;
      end
      m.stop();
   endtask : read_from
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 80000) begin
         failures++;
         test_done();
      end
   end
   initial begin
      logic [7:0] q;
      logic a;
      repeat (16) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      check(pll_o.slow_clock_div, 4'hA);
      check(tune_adc_latch_o, 1'b0);
      read_from(8'h06, 13);
      foreach (rows[i]) check(got[i], rows[i][1]);
      $display("reset values done");
      m.start();
      dev_byte(8'hC0);
      dev_byte(8'h06);
      // Shutdown byte sets the bandgap bit too, so bandgap_off can go high
      foreach (rows[i]) dev_byte(rows[i][0]);
      m.stop();
      repeat (4) @(negedge clk_i);
      check(pll_o.slow_clock_div, 4'h2);
      check(pll_o.pump_auto, 1'b1);
      check(pll_o.pump_high, 1'b0);
      check(pll_o.lock_pin_select, 3'h7);
      check(analog_o.osc_subband_sel, 3'h0);
      check(analog_o.offset_mode, 2'h0);
      check(pll_o.ref_div_two, 1'b0);
      check(pll_o.pump_test_mode, PUMP_HIGH_Z);
      check(power_o.lna_off, 1'b1);
      check(power_o.bandgap_off, 1'b1);
      check(power_o.xtal_off, 1'b1);
      check(power_o.osc_off, 1'b1);
      check(analog_o.band_auto_sel, 1'b1);
      check(tune_adc_latch_o, 1'b1);
      check(analog_o.offset_threshold, 2'h3);
      check(analog_o.offset_hold, 1'b1);
      check(analog_o.offset_dac_value, 9'h1A5);
      check(fuse_addr_o, 8'h03);
      check(fuse_data_o, 8'h96);
      read_from(8'h06, 13);
      foreach (rows[i]) check(got[i], rows[i][2]);
      $display("burst write and read done");
      nrst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      read_from(8'h11, 1);
      check(got[0], 8'hB9);
      m.start();
      m.xfer(8'hC4, 1'b1, q, a);
      check(a, 1'b1);
      m.stop();
      $display("power flag and address refusal done");
      test_done();
   end
endmodule : test_tuner_control_register_bank
bind tuner_control_register_bank tuner_control_register_bank_monitor mon (.clk_i(clk_i),
   .nrst_i(nrst_i), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o), .pll_o(pll_o),
   .power_o(power_o), .analog_o(analog_o));
